// file: ecf_pkg.sv
// Purpose: Shared constants and types for the CAN error-confinement block
// Assumes: One bit-time strobe per nominal CAN bit
// Notes: Counts are in CAN bit times unless the name says cycles
package ecf_pkg;
	localparam int ECF_CNT_W = 9;
	localparam logic [8:0] ECF_CNT_RESET = 9'h000;
	localparam logic [8:0] ECF_CNT_INC = 9'h008;
	localparam logic [8:0] ECF_CNT_DEC = 9'h001;
	localparam logic [8:0] ECF_WARN_LIMIT = 9'h060;
	localparam logic [8:0] ECF_PASSIVE_LIMIT = 9'h07F;
	localparam logic [8:0] ECF_BUSOFF_LIMIT = 9'h0FF;
	localparam logic [3:0] ECF_ACT_FLAG_BITS = 4'h6;
	localparam logic [3:0] ECF_PAS_FLAG_BITS = 4'h6;
	localparam logic [3:0] ECF_DELIM_BITS = 4'h7;
	localparam logic [3:0] ECF_SUSPEND_BITS = 4'h8;
	localparam logic [3:0] ECF_BUS_FREE_BITS = 4'hB;
	localparam logic [3:0] ECF_BITCNT_RESET = 4'h0;
	typedef enum logic [1:0] {ECF_ACTIVE, ECF_PASSIVE, ECF_BUSOFF} ecf_state_t;
	typedef enum logic [1:0] {ECF_FL_IDLE, ECF_FL_FLAG, ECF_FL_WAIT, ECF_FL_DELIM} ecf_flag_t;
endpackage

// file: ecf_counter.sv
// Purpose: One saturating error counter
// Assumes: Strobes are one-cycle pulses qualified by the caller
// Notes: Clear beats increment, increment beats decrement
`timescale 1ns/1ps
`default_nettype none
module ecf_counter #(
	parameter int WIDTH = ecf_pkg::ECF_CNT_W
) (
	input wire logic i_clk,
	input wire logic i_resetn,
	input wire logic i_en,
	input wire logic i_clear,
	input wire logic i_inc,
	input wire logic i_dec,
	output logic [WIDTH-1:0] o_count
);
	import ecf_pkg::*;
	if (WIDTH < ECF_CNT_W) begin : g_width_check
		$error("ecf_counter: WIDTH too small");
	end
	localparam logic [WIDTH-1:0] MAXV = '1;
	localparam logic [WIDTH-1:0] INCV = WIDTH'(ECF_CNT_INC);
	localparam logic [WIDTH-1:0] DECV = WIDTH'(ECF_CNT_DEC);
	wire logic at_top = (o_count > (MAXV - INCV));
	wire logic at_zero = (o_count < DECV);
	wire logic [WIDTH-1:0] next_count = i_clear ? WIDTH'(ECF_CNT_RESET) :
		i_inc ? (at_top ? MAXV : o_count + INCV) :
		i_dec ? (at_zero ? WIDTH'(ECF_CNT_RESET) : o_count - DECV) :
		o_count;
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_count <= WIDTH'(ECF_CNT_RESET);
		end else if (i_en) begin
			o_count <= next_count;
		end
	end
endmodule
`default_nettype wire

// file: ecf_core.sv
// Purpose: CAN error confinement: fault states, error flags, suspend, start-up
// Assumes: Frame logic classifies errors and successes and strobes them once
// Notes: Bus level 1 is recessive, 0 dominant
`timescale 1ns/1ps
`default_nettype none
module ecf_core #(
	parameter int CNT_W = ecf_pkg::ECF_CNT_W
) (
	input wire logic i_clk,
	input wire logic i_resetn,
	input wire logic i_en,
	input wire logic i_bit_tick,
	input wire logic i_rx_bit,
	input wire logic i_err_detect,
	input wire logic i_foreign_flag,
	input wire logic i_tx_err,
	input wire logic i_tx_ack_err,
	input wire logic i_rx_err,
	input wire logic i_tx_ok,
	input wire logic i_rx_ok,
	input wire logic i_ack_slot,
	input wire logic i_tx_done,
	input wire logic i_reset_req,
	input wire logic i_cnt_clear,
	output logic o_tx_bit,
	output ecf_pkg::ecf_state_t o_state,
	output logic o_tx_allow,
	output logic o_rx_allow,
	output logic o_err_warn,
	output logic o_err_irq,
	output logic o_flag_busy,
	output logic [CNT_W-1:0] o_tec,
	output logic [CNT_W-1:0] o_rec
);
	import ecf_pkg::*;
	if (CNT_W < ECF_CNT_W) begin : g_width_check
		$error("ecf_core: CNT_W too small");
	end

	function automatic logic above(input logic [CNT_W-1:0] v, input logic [8:0] lim);
		above = (v > CNT_W'(lim));
	endfunction

	logic [CNT_W-1:0] tec;
	logic [CNT_W-1:0] rec;
	ecf_flag_t flag_st;
	logic flag_dom;
	logic [3:0] bit_cnt;
	logic last_rx;
	logic susp;
	logic [3:0] susp_cnt;
	logic synced;
	logic [3:0] sync_cnt;
	logic warn_q;
	logic busoff_seen_q;

	wire logic tick = i_en & i_bit_tick;
	wire logic busoff = (o_state == ECF_BUSOFF);
	wire logic passive = (o_state == ECF_PASSIVE);
	wire logic any_err = i_err_detect | i_foreign_flag;
	wire logic release_ok = !i_reset_req && (tec == '0) && (rec == '0);
	wire logic tx_inc = i_tx_err && !busoff && !(i_tx_ack_err && passive);
	wire logic rx_inc = i_rx_err && !busoff;
	wire logic tx_dec = i_tx_ok && !busoff;
	wire logic rx_dec = i_rx_ok && !busoff;
	wire logic cnt_clear = i_cnt_clear && busoff;

	ecf_counter #(.WIDTH(CNT_W)) u_tec (
		.i_clk(i_clk), .i_resetn(i_resetn), .i_en(i_en), .i_clear(cnt_clear),
		.i_inc(tx_inc), .i_dec(tx_dec), .o_count(tec)
	);
	ecf_counter #(.WIDTH(CNT_W)) u_rec (
		.i_clk(i_clk), .i_resetn(i_resetn), .i_en(i_en), .i_clear(cnt_clear),
		.i_inc(rx_inc), .i_dec(rx_dec), .o_count(rec)
	);

	// Fault state from counters, bus-off held until release
	wire logic enter_busoff = !busoff && above(tec, ECF_BUSOFF_LIMIT);
	wire logic leave_busoff = busoff && release_ok;
	wire logic go_passive = above(tec, ECF_PASSIVE_LIMIT) || above(rec, ECF_PASSIVE_LIMIT);
	wire ecf_state_t next_state = enter_busoff ? ECF_BUSOFF :
		(busoff && !release_ok) ? ECF_BUSOFF :
		go_passive ? ECF_PASSIVE : ECF_ACTIVE;

	// Error flag sequencer
	wire logic flag_start = tick && any_err && !busoff &&
		(flag_st == ECF_FL_IDLE || (flag_st == ECF_FL_DELIM && !i_rx_bit));
	wire logic [3:0] next_run = (i_rx_bit == last_rx) ? bit_cnt + 4'h1 : 4'h1;
	wire logic act_done = flag_dom && (bit_cnt == ECF_ACT_FLAG_BITS - 4'h1);
	wire logic pas_done = !flag_dom && (next_run == ECF_PAS_FLAG_BITS);
	ecf_flag_t next_flag;
	logic [3:0] next_bit_cnt;
	always_comb begin
		next_flag = flag_st;
		next_bit_cnt = bit_cnt;
		if (flag_start) begin
			next_flag = ECF_FL_FLAG;
			next_bit_cnt = ECF_BITCNT_RESET;
		end else if (tick) begin
			unique case (flag_st)
				ECF_FL_IDLE: begin
					next_bit_cnt = ECF_BITCNT_RESET;
				end
				ECF_FL_FLAG: begin
					if (act_done || pas_done) begin
						next_flag = ECF_FL_WAIT;
						next_bit_cnt = ECF_BITCNT_RESET;
					end else begin
						next_bit_cnt = flag_dom ? bit_cnt + 4'h1 : next_run;
					end
				end
				ECF_FL_WAIT: begin
					if (i_rx_bit) begin
						next_flag = ECF_FL_DELIM;
						next_bit_cnt = ECF_BITCNT_RESET;
					end
				end
				ECF_FL_DELIM: begin
					if (bit_cnt == ECF_DELIM_BITS - 4'h1) begin
						next_flag = ECF_FL_IDLE;
					end else begin
						next_bit_cnt = bit_cnt + 4'h1;
					end
				end
			endcase
		end
	end

	// Suspend transmission and bus-free sync
	wire logic susp_start = i_en && i_tx_done && passive;
	wire logic susp_end = tick && (!i_rx_bit || susp_cnt == ECF_SUSPEND_BITS - 4'h1);
	wire logic sync_hit = tick && i_rx_bit && (sync_cnt == ECF_BUS_FREE_BITS - 4'h1);
	wire logic [3:0] next_sync_cnt = !tick ? sync_cnt :
		(!i_rx_bit || synced) ? ECF_BITCNT_RESET : sync_cnt + 4'h1;

	wire logic warn_now = above(tec, ECF_WARN_LIMIT) || above(rec, ECF_WARN_LIMIT);
	wire logic recover = busoff_seen_q && sync_hit;
	wire logic next_irq = (warn_now && !warn_q) || enter_busoff || recover;
	wire ecf_flag_t flag_nx_eff = next_flag;
	wire logic next_dom_flag = flag_start ? (o_state == ECF_ACTIVE) : flag_dom;
	wire logic ack_drive = i_ack_slot && !busoff;
	wire logic next_tx_bit = !((flag_nx_eff == ECF_FL_FLAG && next_dom_flag) || ack_drive);
	wire logic next_synced = leave_busoff ? 1'b0 : (synced || sync_hit);
	wire logic next_susp = susp_start ? 1'b1 : (susp_end ? 1'b0 : susp);
	wire logic next_tx_allow = next_synced && !susp_start && !next_susp &&
		(next_state != ECF_BUSOFF) && (next_flag == ECF_FL_IDLE);

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_state <= ECF_ACTIVE;
			flag_st <= ECF_FL_IDLE;
			flag_dom <= 1'b0;
			bit_cnt <= ECF_BITCNT_RESET;
			last_rx <= 1'b1;
			susp <= 1'b0;
			susp_cnt <= ECF_BITCNT_RESET;
			synced <= 1'b0;
			sync_cnt <= ECF_BITCNT_RESET;
			warn_q <= 1'b0;
			busoff_seen_q <= 1'b0;
			o_tx_bit <= 1'b1;
			o_tx_allow <= 1'b0;
			o_rx_allow <= 1'b0;
			o_err_warn <= 1'b0;
			o_err_irq <= 1'b0;
			o_flag_busy <= 1'b0;
		end else if (i_en) begin
			o_state <= next_state;
			flag_st <= next_flag;
			flag_dom <= next_dom_flag;
			bit_cnt <= next_bit_cnt;
			last_rx <= tick ? i_rx_bit : last_rx;
			susp <= next_susp;
			susp_cnt <= (susp_start || !tick) ? (susp_start ? ECF_BITCNT_RESET : susp_cnt) :
				susp_cnt + 4'h1;
			synced <= next_synced;
			sync_cnt <= leave_busoff ? ECF_BITCNT_RESET : next_sync_cnt;
			warn_q <= warn_now;
			busoff_seen_q <= leave_busoff ? 1'b1 : (recover ? 1'b0 : busoff_seen_q);
			o_tx_bit <= next_tx_bit;
			o_tx_allow <= next_tx_allow;
			o_rx_allow <= (next_state != ECF_BUSOFF) && (next_flag == ECF_FL_IDLE);
			o_err_warn <= warn_now;
			o_err_irq <= next_irq;
			o_flag_busy <= (next_flag != ECF_FL_IDLE);
		end
	end
	assign o_tec = tec;
	assign o_rec = rec;

	sequence s_err_tick;
		tick && any_err && flag_st == ECF_FL_IDLE && !busoff;
	endsequence
	sequence s_flag_up;
		##1 (flag_st == ECF_FL_FLAG);
	endsequence

	AST_FOREIGN_FLAG: assert property (@(posedge i_clk) disable iff (!i_resetn)
		(s_err_tick and (i_foreign_flag && !i_err_detect)) |-> s_flag_up)
		else $error("foreign flag did not start error flag");
	AST_BUSOFF_SILENT: assert property (@(posedge i_clk) disable iff (!i_resetn)
		(busoff && !release_ok) |-> ##1 (!o_tx_allow && !o_rx_allow))
		else $error("traffic allowed during bus-off");
	AST_ACK_DRIVE: assert property (@(posedge i_clk) disable iff (!i_resetn)
		(i_en && i_ack_slot && !busoff) |=> !o_tx_bit)
		else $error("acknowledge not driven dominant");
	AST_ACTIVE_FLAG: assert property (@(posedge i_clk) disable iff (!i_resetn)
		(s_err_tick and (o_state == ECF_ACTIVE)) |=> (flag_dom && !o_tx_bit))
		else $error("active flag not dominant");
	AST_PASSIVE_FLAG: assert property (@(posedge i_clk) disable iff (!i_resetn)
		(s_err_tick and (passive && !i_ack_slot)) |=> (!flag_dom && o_tx_bit))
		else $error("passive flag not recessive");
	AST_SUSPEND: assert property (@(posedge i_clk) disable iff (!i_resetn)
		(susp_start && !tick) |=> !o_tx_allow)
		else $error("transmit allowed during suspend");
	AST_BUS_FREE: assert property (@(posedge i_clk) disable iff (!i_resetn)
		(!synced && !sync_hit) |=> !o_tx_allow)
		else $error("transmit before bus free");
	AST_ACK_NO_BUSOFF: assert property (@(posedge i_clk) disable iff (!i_resetn)
		(i_en && passive && i_tx_err && i_tx_ack_err && !i_cnt_clear) |=> (tec <= $past(tec)))
		else $error("ack error raised transmit counter while passive");
	AST_INC_EIGHT: assert property (@(posedge i_clk) disable iff (!i_resetn)
		(i_en && rx_inc && !cnt_clear && rec < CNT_W'(9'h0F0)) |=> (rec == $past(rec) + 9'h008))
		else $error("receive counter increment not eight");
	AST_DEC_FLOOR: assert property (@(posedge i_clk) disable iff (!i_resetn)
		(i_en && rx_dec && !rx_inc && !cnt_clear && rec == '0) |=> (rec == '0))
		else $error("receive counter wrapped below zero");
	AST_PASSIVE_ENTRY: assert property (@(posedge i_clk) disable iff (!i_resetn)
		(i_en && !busoff && !enter_busoff && go_passive) |=> (o_state == ECF_PASSIVE))
		else $error("passive state not entered above 127");
	AST_BUSOFF_ENTRY: assert property (@(posedge i_clk) disable iff (!i_resetn)
		(i_en && enter_busoff) |=> (busoff && o_err_irq))
		else $error("bus-off entry or its interrupt missing");
	AST_WARN_IRQ: assert property (@(posedge i_clk) disable iff (!i_resetn)
		(i_en && warn_now && !warn_q) |=> (o_err_warn && o_err_irq))
		else $error("warning status or interrupt missing");
	AST_DELIM_LEN: assert property (@(posedge i_clk) disable iff (!i_resetn)
		(i_en && flag_st == ECF_FL_WAIT && next_flag == ECF_FL_DELIM) |=> (bit_cnt == 4'h0))
		else $error("delimiter count not restarted");
endmodule
`default_nettype wire

// file: ecf_bus_model.sv
// Purpose: Other CAN nodes on the shared line: bit timing and wired-AND level
// Assumes: One sample point every four clocks, 1 recessive, 0 dominant
// Notes: Other nodes pull dominant only while i_node_bit is low
`timescale 1ns/1ps
`default_nettype none
module ecf_bus_model (
	input wire logic i_clk,
	input wire logic i_resetn,
	input wire logic i_node_bit,
	input wire logic i_dut_bit,
	output logic o_tick,
	output logic o_bus
);
	logic [1:0] phase;
	// Any dominant driver wins the line
	assign o_bus = i_node_bit & i_dut_bit;
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			phase <= 2'h0;
			o_tick <= 1'b0;
		end else begin
			phase <= phase + 2'h1;
			o_tick <= (phase == 2'h3);
		end
	end
endmodule
`default_nettype wire

// file: test_can_error_confinement.sv
// Purpose: Self-checking bench for the error-confinement core
// Assumes: Bus model gives a tick every four clocks
// Notes: Random receive traffic from a fixed-seed LFSR
`timescale 1ns/1ps
`default_nettype none
module test_can_error_confinement;
	import ecf_pkg::*;
	logic i_clk, i_resetn, i_en, tick, bus, node_bit;
	logic err_det, foreign, tx_err, ack_err, rx_err, tx_ok, rx_ok, ack_slot, tx_done, req, clr;
	logic o_tx_bit, o_tx_allow, o_rx_allow, o_err_warn, o_err_irq, o_flag_busy;
	ecf_state_t o_state;
	logic [8:0] o_tec, o_rec, rec_m, tec_m, old;
	logic [31:0] lfsr;
	int n_fail, check_count, k;
	localparam int S_ERR = 0;
	localparam int S_FOREIGN = 1;
	localparam int S_TXERR = 2;
	localparam int S_RXERR = 3;
	localparam int S_TXOK = 4;
	localparam int S_RXOK = 5;
	localparam int S_ACK = 6;
	localparam int S_DONE = 7;
	ecf_core ecf_core_inst (.i_clk(i_clk), .i_resetn(i_resetn), .i_en(i_en), .i_bit_tick(tick),
		.i_rx_bit(bus), .i_err_detect(err_det), .i_foreign_flag(foreign), .i_tx_err(tx_err),
		.i_tx_ack_err(ack_err), .i_rx_err(rx_err), .i_tx_ok(tx_ok), .i_rx_ok(rx_ok),
		.i_ack_slot(ack_slot), .i_tx_done(tx_done), .i_reset_req(req), .i_cnt_clear(clr),
		.o_tx_bit(o_tx_bit), .o_state(o_state), .o_tx_allow(o_tx_allow), .o_rx_allow(o_rx_allow),
		.o_err_warn(o_err_warn), .o_err_irq(o_err_irq), .o_flag_busy(o_flag_busy),
		.o_tec(o_tec), .o_rec(o_rec));
	ecf_bus_model ecf_bus_model_inst (.i_clk(i_clk), .i_resetn(i_resetn), .i_node_bit(node_bit),
		.i_dut_bit(o_tx_bit), .o_tick(tick), .o_bus(bus));
	initial begin
		i_clk = 1'b0;
		forever #5 i_clk = ~i_clk;
	end
	function automatic logic [31:0] lfsr_next(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function automatic logic [8:0] cnt_after(input logic [8:0] c, input bit err);
		if (err) return (c > 9'h1F7) ? 9'h1FF : c + ECF_CNT_INC;
		return (c == 9'h000) ? 9'h000 : c - ECF_CNT_DEC;
	endfunction
	function automatic ecf_state_t state_of(input logic [8:0] t, input logic [8:0] r);
		return (t > 9'h07F || r > 9'h07F) ? ECF_PASSIVE : ECF_ACTIVE;
	endfunction
	task automatic final_report();
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	task automatic chk_bit(input logic g, input logic e);
		check_count++;
		if (g !== e) begin
			n_fail++;
			$display("MISMATCH t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic chk_cnt(input logic [8:0] g, input logic [8:0] e);
		check_count++;
		if (g !== e) begin
			n_fail++;
			$display("MISMATCH t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic chk_state(input ecf_state_t g, input ecf_state_t e);
		check_count++;
		if (g !== e) begin
			n_fail++;
			$display("MISMATCH t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic hang();
		n_fail++;
		final_report();
	endtask
	task automatic put(input int sel, input logic v);
		case (sel)
			S_ERR: err_det <= v;
			S_FOREIGN: foreign <= v;
			S_TXERR: tx_err <= v;
			S_RXERR: rx_err <= v;
			S_TXOK: tx_ok <= v;
			S_RXOK: rx_ok <= v;
			S_ACK: ack_slot <= v;
			default: tx_done <= v;
		endcase
	endtask
	task automatic pulse(input int sel);
		@(posedge i_clk);
		put(sel, 1'b1);
		@(posedge i_clk);
		put(sel, 1'b0);
		#1;
	endtask
	task automatic ticks(input int n);
		repeat (n) begin
			k = 0;
			do begin
				@(posedge i_clk);
				#1;
				k++;
			end while (tick !== 1'b1 && k < 8);
			if (k >= 8) hang();
		end
	endtask
	task automatic tick_err(input int sel);
		ticks(1);
		repeat (4) @(posedge i_clk);
		put(sel, 1'b1);
		@(posedge i_clk);
		put(sel, 1'b0);
		#1;
	endtask
	task automatic wait_idle();
		for (k = 0; k < 400 && o_flag_busy !== 1'b0; k++) @(posedge i_clk);
		if (k >= 400) hang();
		#1;
	endtask
	task automatic rx_step(input bit err);
		old = rec_m;
		rec_m = cnt_after(rec_m, err);
		if (err) pulse(S_RXERR);
		else pulse(S_RXOK);
		chk_cnt(o_rec, rec_m);
		@(posedge i_clk);
		#1;
		chk_bit(o_err_irq, old <= 9'h060 && rec_m > 9'h060);
		chk_bit(o_err_warn, rec_m > 9'h060);
		chk_state(o_state, state_of(tec_m, rec_m));
	endtask
	initial begin
		{err_det, foreign, tx_err, ack_err, rx_err, tx_ok, rx_ok, ack_slot, tx_done, req, clr} = '0;
		i_resetn = 1'b0;
		i_en = 1'b1;
		node_bit = 1'b1;
		lfsr = 32'hBBD374B1;
		n_fail = 0;
		check_count = 0;
		rec_m = 9'h000;
		tec_m = 9'h000;
		repeat (2) @(posedge i_clk);
		#1;
		chk_state(o_state, ECF_ACTIVE);
		chk_bit(o_tx_allow, 1'b0);
		@(posedge i_clk);
		i_resetn <= 1'b1;
		ticks(10);
		@(posedge i_clk);
		#1;
		chk_bit(o_tx_allow, 1'b0);
		ticks(1);
		repeat (2) @(posedge i_clk);
		#1;
		chk_bit(o_tx_allow, 1'b1);
		pulse(S_ACK);
		chk_bit(o_tx_bit, 1'b0);
		tick_err(S_ERR);
		chk_bit(o_tx_bit, 1'b0);
		wait_idle();
		chk_bit(o_err_irq, 1'b0);
		tick_err(S_FOREIGN);
		chk_bit(o_flag_busy, 1'b1);
		wait_idle();
		pulse(S_TXOK);
		chk_cnt(o_tec, 9'h000);
		for (int i = 0; i < 150; i++) begin
			lfsr = lfsr_next(lfsr);
			rx_step(lfsr[1:0] == 2'h0);
		end
		repeat (17) rx_step(1'b1);
		tick_err(S_ERR);
		chk_bit(o_tx_bit, 1'b1);
		chk_bit(o_flag_busy, 1'b1);
		wait_idle();
		ticks(1);
		pulse(S_DONE);
		chk_bit(o_tx_allow, 1'b0);
		ticks(7);
		@(posedge i_clk);
		#1;
		chk_bit(o_tx_allow, 1'b0);
		ticks(1);
		repeat (2) @(posedge i_clk);
		#1;
		chk_bit(o_tx_allow, 1'b1);
		ack_err <= 1'b1;
		pulse(S_TXERR);
		ack_err <= 1'b0;
		chk_cnt(o_tec, 9'h000);
		repeat (32) begin
			tec_m = cnt_after(tec_m, 1'b1);
			pulse(S_TXERR);
			chk_cnt(o_tec, tec_m);
		end
		@(posedge i_clk);
		#1;
		chk_state(o_state, ECF_BUSOFF);
		chk_bit(o_err_irq, 1'b1);
		pulse(S_RXOK);
		chk_cnt(o_rec, rec_m);
		chk_bit(o_rx_allow, 1'b0);
		@(posedge i_clk);
		req <= 1'b1;
		clr <= 1'b1;
		repeat (2) @(posedge i_clk);
		clr <= 1'b0;
		repeat (2) @(posedge i_clk);
		#1;
		chk_cnt(o_tec, 9'h000);
		chk_state(o_state, ECF_BUSOFF);
		@(posedge i_clk);
		req <= 1'b0;
		repeat (2) @(posedge i_clk);
		#1;
		chk_state(o_state, ECF_ACTIVE);
		for (k = 0; k < 100 && o_err_irq !== 1'b1; k++) @(posedge i_clk) #1;
		if (k >= 100) hang();
		chk_bit(o_err_irq, 1'b1);
		chk_bit(o_tx_allow, 1'b1);
		chk_bit(o_rx_allow, 1'b1);
		chk_cnt(o_rec, 9'h000);
		final_report();
	end
endmodule
`default_nettype wire
